/* File: src/ccdg_seq.sv */
// frame, line and pixel clock sequencer that drives the interline ccd
`timescale 1ns/100ps
module ccdg_seq (
    input  wire logic                         mclk,
    input  wire logic                         nrst,
    input  wire logic                         frame_start,
    input  wire logic                         dual_mode,
    input  wire logic                         shutter_en,
    input  wire logic [ccdg_pkg::EXTRA_W-1:0] int_extra,
    output logic                              vreg_phase_one_clk,
    output logic                              vreg_one_xfer_lvl,
    output logic                              vreg_phase_two_clk,
    output logic                              hreg_a_phase_one_clk,
    output logic                              hreg_b_phase_one_clk,
    output logic                              hreg_phase_two_clk,
    output logic                              line_ab_xfer,
    output logic                              out_reset_clk,
    output logic                              clamp_strobe,
    output logic                              sample_strobe,
    output logic                              shutter_pulse,
    output logic                              line_dump_gate_clk,
    output logic                              busy,
    output logic                              frame_done
);
    import ccdg_pkg::*;

    // ****************************************************************
    // state record
    // ****************************************************************
    typedef struct packed {
        ccdg_st_t            st;     // sequencer step
        logic                dual;   // mode caught at frame start
        logic [EXTRA_W-1:0]  extra;  // integration extension, cycles
        logic [9:0]          line;   // line being read
        logic [9:0]          pix;    // pixel within the line
        logic [1:0]          ph;     // phase within the pixel
        logic                v1;     // vertical phase one active
        logic                v1x;    // vertical phase one at transfer level
        logic                v2;     // vertical phase two active
        logic                h1a;    // register a phase one
        logic                h1b;    // register b phase one
        logic                h2;     // common phase two
        logic                rst;    // output reset strobe
        logic                clmp;   // clamp strobe
        logic                smp;    // sample strobe
        logic                shut;   // substrate shutter pulse
        logic                abx;    // line a-to-b transfer pulse
        logic                done;   // one-cycle end of frame
    } ccdg_seq_t;

    ccdg_seq_t     s_q;              // registered state
    ccdg_seq_t     s_d;              // next state
    logic          tmr_load;         // start timing the next step
    logic [TW-1:0] tmr_val;          // length of the next step
    logic          tmr_done;         // current step has run out

    // ****************************************************************
    // helpers
    // ****************************************************************

    // timer load for a step; zero for steps the timer does not pace
    function automatic logic [TW-1:0] step_len(input ccdg_st_t st,
                                               input logic [EXTRA_W-1:0] ext);
        logic [TW-1:0] v;
        v = '0;
        unique case (st)
            CCDG_SHUT:  v = ES_LD;
            CCDG_SHGAP: v = HVES_LD;
            CCDG_INTEG: v = INTR_LD + TW'(ext);
            CCDG_XFER:  v = VH_LD;
            CCDG_RDLY:  v = RD_LD;
            CCDG_VSH1:  v = V_LD;
            CCDG_VSH2:  v = V_LD;
            CCDG_ABX:   v = AB_LD;
            CCDG_HDLY:  v = HD_LD;
            CCDG_IDLE:  v = '0;
            CCDG_PIX:   v = '0;
        endcase
        return v;
    endfunction

    // last pixel index of a line for the caught mode
    function automatic logic [9:0] last_pix(input logic dual);
        return dual ? LAST_PIX_D : LAST_PIX_S;
    endfunction

    // ****************************************************************
    // step timer
    // ****************************************************************
    ccdg_timer u_timer (
        .mclk     (mclk),
        .nrst     (nrst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_done)
    );

    // ****************************************************************
    // next state
    // ****************************************************************

    // the timer is loaded on the same edge the step is entered, so a
    // step never sees a stale expiry from the one before it
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            // wait for a frame request; settings are frozen for the frame
            CCDG_IDLE: begin
                if (frame_start) begin
                    s_d.dual  = dual_mode;
                    s_d.extra = int_extra;
                    s_d.st    = shutter_en ? CCDG_SHUT : CCDG_XFER;
                end
            end
            // shutter pulse on the substrate
            CCDG_SHUT: begin
                if (tmr_done) begin
                    s_d.st = CCDG_SHGAP;
                end
            end
            // quiet gap, counted into the integration time
            CCDG_SHGAP: begin
                if (tmr_done) begin
                    s_d.st = CCDG_INTEG;
                end
            end
            // remaining integration before transfer
            CCDG_INTEG: begin
                if (tmr_done) begin
                    s_d.st = CCDG_XFER;
                end
            end
            CCDG_XFER: begin
                if (tmr_done) begin
                    s_d.st = CCDG_RDLY;
                end
            end
            CCDG_RDLY: begin
                if (tmr_done) begin
                    s_d.st   = CCDG_VSH1;
                    s_d.line = '0;
                end
            end
            // one line shift: phase one, then phase two
            CCDG_VSH1: begin
                if (tmr_done) begin
                    s_d.st = CCDG_VSH2;
                end
            end
            CCDG_VSH2: begin
                if (tmr_done) begin
                    s_d.st = s_q.dual ? CCDG_ABX : CCDG_HDLY;
                end
            end
            // dual only: pass the line on to register b
            CCDG_ABX: begin
                if (tmr_done) begin
                    s_d.st = CCDG_HDLY;
                end
            end
            // settle before pixel clocking
            CCDG_HDLY: begin
                if (tmr_done) begin
                    s_d.st  = CCDG_PIX;
                    s_d.pix = '0;
                    s_d.ph  = '0;
                end
            end
            // read the line, then next shift, or idle after the last line
            CCDG_PIX: begin
                s_d.ph = s_q.ph + 2'h1;
                if (s_q.ph == PH_LAST) begin
                    if (s_q.pix != last_pix(s_q.dual)) begin
                        s_d.pix = s_q.pix + 10'h1;
                    end else if (s_q.line != LAST_LINE) begin
                        s_d.line = s_q.line + 10'h1;
                        s_d.st   = CCDG_VSH1;
                    end else begin
                        s_d.st   = CCDG_IDLE;
                        s_d.done = 1'b1;
                    end
                end
            end
        endcase

        // pin levels follow the step being entered, so they are registered
        s_d.v1x  = (s_d.st == CCDG_XFER);
        s_d.v1   = (s_d.st == CCDG_XFER) || (s_d.st == CCDG_VSH1);
        s_d.v2   = (s_d.st == CCDG_VSH2);
        s_d.shut = (s_d.st == CCDG_SHUT);
        s_d.abx  = (s_d.st == CCDG_ABX);
        s_d.h1a  = (s_d.st == CCDG_PIX) && (s_d.ph < PH_H2);
        s_d.h2   = (s_d.st == CCDG_PIX) && (s_d.ph >= PH_H2);
        s_d.h1b  = s_d.dual ? s_d.h1a : HB_LOW;
        s_d.rst  = (s_d.st == CCDG_PIX) && (s_d.ph == PH_RST);
        s_d.clmp = (s_d.st == CCDG_PIX) && (s_d.ph == PH_CLAMP);
        s_d.smp  = (s_d.st == CCDG_PIX) && (s_d.ph == PH_SAMPLE);
    end

    // timer is restarted only when a timed step is entered
    always_comb begin
        tmr_val  = step_len(s_d.st, s_d.extra);
        tmr_load = (s_d.st != s_q.st) && (s_d.st != CCDG_IDLE) && (s_d.st != CCDG_PIX);
    end

    // ****************************************************************
    // state register
    // ****************************************************************

    // reset leaves every clock at its quiet level and the step idle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign vreg_phase_one_clk   = s_q.v1;
    assign vreg_one_xfer_lvl    = s_q.v1x;
    assign vreg_phase_two_clk   = s_q.v2;
    assign hreg_a_phase_one_clk = s_q.h1a;
    assign hreg_b_phase_one_clk = s_q.h1b;
    assign hreg_phase_two_clk   = s_q.h2;
    assign line_ab_xfer         = s_q.abx;
    assign out_reset_clk        = s_q.rst;
    assign clamp_strobe         = s_q.clmp;
    assign sample_strobe        = s_q.smp;
    assign shutter_pulse        = s_q.shut;
    // dump gate held at static level
    assign line_dump_gate_clk   = DUMP_STATIC;
    assign busy                 = (s_q.st != CCDG_IDLE);
    assign frame_done           = s_q.done;

endmodule

/* File: src/ccdg_pkg.sv */
// constants, states and timing counts for the ccd clock sequence generator
package ccdg_pkg;

    // ****************************************************************
    // clock and timing figures
    // ****************************************************************
    localparam int CLK_NS   = 40;      // mclk period at 25 MHz
    localparam int ES_NS    = 25000;   // shutter pulse, nominal width
    localparam int INT_NS   = 100000;  // least integration time
    localparam int VH_NS    = 5000;    // photodiode transfer, nominal width
    localparam int RD_NS    = 10000;   // vertical readout delay, least
    localparam int V_NS     = 3000;    // vertical shift pulse, least
    localparam int AB_NS    = 3000;    // line a-to-b transfer, nominal
    localparam int HD_NS    = 3000;    // horizontal delay, least
    localparam int HVES_NS  = 1000;    // horizontal delay after shutter
    localparam int H_MHZ    = 20;      // nominal horizontal clock rate

    // least times round up to whole cycles
    localparam int ES_CYC   = (ES_NS + CLK_NS - 1) / CLK_NS;
    localparam int INT_CYC  = (INT_NS + CLK_NS - 1) / CLK_NS;
    localparam int VH_CYC   = (VH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC   = (RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int V_CYC    = (V_NS + CLK_NS - 1) / CLK_NS;
    localparam int AB_CYC   = (AB_NS + CLK_NS - 1) / CLK_NS;
    localparam int HD_CYC   = (HD_NS + CLK_NS - 1) / CLK_NS;
    localparam int HVES_CYC = (HVES_NS + CLK_NS - 1) / CLK_NS;
    // nominal horizontal period in mclk cycles (rounds to one at 25 MHz)
    localparam int H_NOM_CYC = ((1000 / H_MHZ) / CLK_NS) < 1 ? 1 : (1000 / H_MHZ) / CLK_NS;

    // ****************************************************************
    // timer loads: a state lasts load + 1 cycles
    // ****************************************************************
    localparam int            TW       = 16;
    localparam logic [TW-1:0] ES_LD    = TW'(ES_CYC - 1);
    localparam logic [TW-1:0] HVES_LD  = TW'(HVES_CYC - 1);
    localparam logic [TW-1:0] INTR_LD  = TW'(INT_CYC - HVES_CYC - 1);
    localparam logic [TW-1:0] VH_LD    = TW'(VH_CYC - 1);
    localparam logic [TW-1:0] RD_LD    = TW'(RD_CYC - 1);
    localparam logic [TW-1:0] V_LD     = TW'(V_CYC - 1);
    localparam logic [TW-1:0] AB_LD    = TW'(AB_CYC - 1);
    localparam logic [TW-1:0] HD_LD    = TW'(HD_CYC - 1);
    localparam int            EXTRA_W  = 14;  // integration extension width

    // ****************************************************************
    // geometry and pixel phases
    // ****************************************************************
    localparam logic [9:0] LAST_LINE   = 10'h3ff;  // 1024 lines per frame
    localparam logic [9:0] LAST_PIX_S  = 10'h3ff;  // one register: 1024 pixels
    localparam logic [9:0] LAST_PIX_D  = 10'h1ff;  // two registers: 512 each
    localparam logic [1:0] PH_RST      = 2'h0;     // output reset strobe phase
    localparam logic [1:0] PH_CLAMP    = 2'h1;     // clamp strobe phase
    localparam logic [1:0] PH_SAMPLE   = 2'h2;     // sample strobe phase
    localparam logic [1:0] PH_LAST     = 2'h3;     // last phase of a pixel
    localparam logic [1:0] PH_H2       = 2'h2;     // first phase with h2 high
    localparam logic       DUMP_STATIC = 1'b0;     // dump gate static level
    localparam logic       HB_LOW      = 1'b0;     // idle level of register b

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        CCDG_IDLE,
        CCDG_SHUT,
        CCDG_SHGAP,
        CCDG_INTEG,
        CCDG_XFER,
        CCDG_RDLY,
        CCDG_VSH1,
        CCDG_VSH2,
        CCDG_ABX,
        CCDG_HDLY,
        CCDG_PIX
    } ccdg_st_t;

endpackage

/* File: src/ccdg_timer.sv */
// down counter that times each step of the sequence except idle and pixel readout
`timescale 1ns/100ps
module ccdg_timer (
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire logic                    load,
    input  wire logic [ccdg_pkg::TW-1:0] load_val,
    output logic                         expired
);
    import ccdg_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [TW-1:0] cnt;    // cycles still to run
    } ccdg_tmr_t;

    ccdg_tmr_t s_q;            // registered state
    ccdg_tmr_t s_d;            // next state

    // load wins; otherwise count down and rest at zero
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.cnt = load_val;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - TW'(1);
        end
    end

    // plain register, cleared to zero at reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // comes straight from the counter register
    assign expired = (s_q.cnt == '0);

endmodule

/* File: tb/ccdg_seq_checker.sv */
// port assertions for the ccd clock sequencer
`timescale 1ns/100ps
module ccdg_seq_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic frame_start,
    input wire logic dual_mode,
    input wire logic vreg_one_xfer_lvl,
    input wire logic vreg_phase_two_clk,
    input wire logic hreg_a_phase_one_clk,
    input wire logic hreg_b_phase_one_clk,
    input wire logic hreg_phase_two_clk,
    input wire logic line_ab_xfer,
    input wire logic out_reset_clk,
    input wire logic clamp_strobe,
    input wire logic sample_strobe,
    input wire logic shutter_pulse,
    input wire logic line_dump_gate_clk,
    input wire logic busy,
    input wire logic frame_done
);
    import ccdg_pkg::*;
    // ******************************
    // helper state
    // ******************************
    logic        live_q;     // past the first edge after reset
    logic        dual_q;     // mode caught at the take edge
    logic        sflag_q;    // shutter seen, transfer not yet
    logic [15:0] sg_q;       // cycles since shutter end
    logic [15:0] cnt_q [4];  // high-run lengths
    logic [3:0]  hi;         // timed pins
    assign hi = {line_ab_xfer, vreg_phase_two_clk, vreg_one_xfer_lvl, shutter_pulse};
    // runs clear on low, so a fall sees the whole width
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            live_q  <= 1'b0;
            dual_q  <= 1'b0;
            sflag_q <= 1'b0;
            sg_q    <= 16'h0;
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= 16'h0;
            end
        end else begin
            live_q  <= 1'b1;
            if (frame_start && !busy) begin
                dual_q <= dual_mode;
            end
            sflag_q <= shutter_pulse | (sflag_q & ~vreg_one_xfer_lvl);
            sg_q    <= shutter_pulse ? 16'h0 : sg_q + 16'h1;
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= hi[i] ? cnt_q[i] + 16'h1 : 16'h0;
            end
        end
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // ******************************
    // assertions
    // ******************************
    a_take_start:
        assert property (live_q && frame_start && !busy
            |=> busy && (shutter_pulse || vreg_one_xfer_lvl))
        else $error("frame start not taken");
    a_idle_quiet:
        assert property (!busy
            |-> !(shutter_pulse | vreg_one_xfer_lvl | line_ab_xfer | hreg_a_phase_one_clk))
        else $error("pin active while idle");
    a_done_end:
        assert property (live_q |-> frame_done == $fell(busy))
        else $error("frame done not at end of frame");
    a_b_held_low:
        assert property (!dual_q |-> !hreg_b_phase_one_clk)
        else $error("register b clocked in single mode");
    a_b_copies_a:
        assert property (dual_q |-> hreg_b_phase_one_clk == hreg_a_phase_one_clk)
        else $error("register b not with register a");
    a_shut_width:
        assert property (live_q && $fell(shutter_pulse) |-> int'(cnt_q[0]) == ES_CYC)
        else $error("shutter width wrong");
    a_xfer_width:
        assert property (live_q && $fell(vreg_one_xfer_lvl) |-> int'(cnt_q[1]) == VH_CYC)
        else $error("transfer width wrong");
    a_vsh_width:
        assert property (live_q && $fell(vreg_phase_two_clk) |-> int'(cnt_q[2]) == V_CYC)
        else $error("vertical shift width wrong");
    a_ab_width:
        assert property (live_q && $fell(line_ab_xfer) |-> int'(cnt_q[3]) == AB_CYC)
        else $error("line a-to-b width wrong");
    a_integ_min:
        assert property (live_q && sflag_q && $rose(vreg_one_xfer_lvl) |-> int'(sg_q) >= INT_CYC)
        else $error("integration too short");
    a_shut_hgap:
        assert property (sflag_q && int'(sg_q) < HVES_CYC
            |-> !hreg_a_phase_one_clk && !hreg_phase_two_clk)
        else $error("horizontal clock too soon after shutter");
    a_dump_static:
        assert property (line_dump_gate_clk == DUMP_STATIC)
        else $error("dump gate not static");
    a_pixel_order:
        assert property (out_reset_clk |-> hreg_a_phase_one_clk
            ##1 (clamp_strobe && hreg_a_phase_one_clk)
            ##1 (sample_strobe && hreg_phase_two_clk && !hreg_a_phase_one_clk)
            ##1 hreg_phase_two_clk)
        else $error("pixel strobe order wrong");
endmodule

/* File: tb/ccdg_sensor_model.sv */
// behavioural model of the sensor behind the clock pins
`timescale 1ns/100ps
module ccdg_sensor_model (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic shutter_pulse,
    input  wire logic vreg_one_xfer_lvl,
    input  wire logic line_dump_gate_clk,
    output logic      ab_on,
    output logic      dump_on,
    output int        int_cyc
);
    import ccdg_pkg::*;
    int   run;   // cycles since integration began
    logic xf_q;  // transfer level at last edge
    // blooming guard off while transfer high
    assign ab_on = !vreg_one_xfer_lvl;
    assign dump_on = (line_dump_gate_clk !== DUMP_STATIC);
    // shutter restarts integration, else it spans transfer to transfer
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run = 0;
            int_cyc = 0;
            xf_q = 1'b0;
        end else begin
            if (vreg_one_xfer_lvl && !xf_q) begin
                int_cyc = run;
                run = 0;
            end
            run = shutter_pulse ? 0 : run + 1;
            xf_q = vreg_one_xfer_lvl;
        end
    end
endmodule

/* File: tb/ccdg_seq_tb_top.sv */
// self-checking bench for the ccd clock sequencer
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
    begin \
        checked++; \
        if ((gt) !== (ex)) begin \
            fail_count++; \
            $display("BAD %s exp %0d got %0d", nm, ex, gt); \
        end \
    end
module ccdg_seq_tb_top;
    import ccdg_pkg::*;
    typedef struct {
        int k;
        int gap;
        int wid;
    } ccdg_step_t;                          // expected gap then high run
    logic               mclk        = 1'b0;
    logic               nrst        = 1'b0;
    logic               frame_start = 1'b0;
    logic               dual_mode   = 1'b0;
    logic               shutter_en  = 1'b0;
    logic [EXTRA_W-1:0] int_extra   = '0;
    logic               v1, xl, v2, h1a, h1b, h2, abx;
    logic               rst, clp, smp, sht, dg, busy, done;
    logic               ab_on, dump_on;
    int                 int_cyc, extra, n, bad;
    int                 fail_count  = 0;
    int                 checked     = 0;
    ccdg_step_t         sq[$];
    always #20 mclk = ~mclk;
    ccdg_seq u_dut (.mclk(mclk), .nrst(nrst), .frame_start(frame_start),
        .dual_mode(dual_mode), .shutter_en(shutter_en), .int_extra(int_extra),
        .vreg_phase_one_clk(v1), .vreg_one_xfer_lvl(xl), .vreg_phase_two_clk(v2),
        .hreg_a_phase_one_clk(h1a), .hreg_b_phase_one_clk(h1b), .hreg_phase_two_clk(h2),
        .line_ab_xfer(abx), .out_reset_clk(rst), .clamp_strobe(clp), .sample_strobe(smp),
        .shutter_pulse(sht), .line_dump_gate_clk(dg), .busy(busy), .frame_done(done));
    ccdg_sensor_model u_dev (.mclk(mclk), .nrst(nrst), .shutter_pulse(sht),
        .vreg_one_xfer_lvl(xl), .line_dump_gate_clk(dg), .ab_on(ab_on),
        .dump_on(dump_on), .int_cyc(int_cyc));
    // pin picked by step index
    function automatic logic pin(input int k);
        case (k)
            0: pin = sht;
            1: pin = v1;
            2: pin = v2;
            3: pin = abx;
            4: pin = h1a;
            default: pin = h2;
        endcase
    endfunction
    task automatic do_reset();
        @(negedge mclk);
        nrst = 1'b0;
        repeat (6) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
    endtask
    task automatic start_frame(input logic d, input logic s, input int x);
        @(negedge mclk);
        dual_mode = d;
        shutter_en = s;
        int_extra = EXTRA_W'(x);
        frame_start = 1'b1;
        @(negedge mclk);
        frame_start = 1'b0;
    endtask
    // measures each queued gap and high run at falling edges
    task automatic run_steps();
        ccdg_step_t s;
        int g;
        int w;
        while (sq.size() > 0) begin
            s = sq.pop_front();
            g = 0;
            w = 0;
            while (pin(s.k) !== 1'b1 && g < 20000) begin
                g++;
                @(negedge mclk);
            end
            while (pin(s.k) === 1'b1 && w < 20000) begin
                w++;
                @(negedge mclk);
            end
            `CHK("gap", s.gap, g)
            `CHK("width", s.wid, w)
        end
    endtask
    // counts pixels of a line and register b slips
    task automatic count_pix();
        logic prev;
        int c;
        prev = 1'b0;
        c = 0;
        n = 1;
        bad = 0;
        while (v1 !== 1'b1 && c < 6000) begin
            if (h1a === 1'b1 && prev !== 1'b1) n++;
            if (h1b !== (dual_mode ? h1a : HB_LOW)) bad++;
            prev = h1a;
            c++;
            @(negedge mclk);
        end
    endtask
    task automatic give_verdict();
        $display("counts checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // hang guard, about three times the planned run
    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        $display("BAD watchdog exp 1 got 0");
        give_verdict();
    end
    initial begin
        void'($urandom(81109));
        do_reset();
        `CHK("busy", 1'b0, busy)
        // single register, no shutter, stray start while busy
        start_frame(1'b0, 1'b0, 0);
        `CHK("xfer", 1'b1, xl)
        `CHK("ab_on", 1'b0, ab_on)
        `CHK("dump_on", 1'b0, dump_on)
        sq.push_back('{1, 0, VH_CYC});
        sq.push_back('{1, RD_CYC, V_CYC});
        sq.push_back('{2, 0, V_CYC});
        sq.push_back('{4, HD_CYC, 2});
        sq.push_back('{5, 0, 2});
        run_steps();
        frame_start = 1'b1;
        count_pix();
        frame_start = 1'b0;
        `CHK("pixels", int'(LAST_PIX_S) + 1, n)
        `CHK("b_slips", 0, bad)
        $display("test single done");
        do_reset();
        // dual register with shutter and random extra integration
        extra = $urandom % 64;
        start_frame(1'b1, 1'b1, extra);
        sq.push_back('{0, 0, ES_CYC});
        sq.push_back('{1, INT_CYC + extra, VH_CYC});
        sq.push_back('{1, RD_CYC, V_CYC});
        sq.push_back('{2, 0, V_CYC});
        sq.push_back('{3, 0, AB_CYC});
        sq.push_back('{4, HD_CYC, 2});
        sq.push_back('{5, 0, 2});
        run_steps();
        `CHK("integ", INT_CYC + extra, int_cyc)
        count_pix();
        `CHK("pixels", int'(LAST_PIX_D) + 1, n)
        `CHK("b_slips", 0, bad)
        $display("test dual done");
        give_verdict();
    end
endmodule
bind ccdg_seq ccdg_seq_checker u_chk (.mclk(mclk), .nrst(nrst), .frame_start(frame_start),
    .dual_mode(dual_mode), .vreg_one_xfer_lvl(vreg_one_xfer_lvl),
    .vreg_phase_two_clk(vreg_phase_two_clk), .hreg_a_phase_one_clk(hreg_a_phase_one_clk),
    .hreg_b_phase_one_clk(hreg_b_phase_one_clk), .hreg_phase_two_clk(hreg_phase_two_clk),
    .line_ab_xfer(line_ab_xfer), .out_reset_clk(out_reset_clk), .clamp_strobe(clamp_strobe),
    .sample_strobe(sample_strobe), .shutter_pulse(shutter_pulse),
    .line_dump_gate_clk(line_dump_gate_clk), .busy(busy), .frame_done(frame_done));
